// ===== hdl/intr_pkg.sv
// Purpose: Shared constants and carriers for the interrupt source classifier
// Assumes: 32-bit APB register words, 20-bit address space of the core
// Notes:   Register offsets are byte addresses on the APB bus
`default_nettype none
package intr_pkg;
   // ==========================================================
   // Register map
   localparam logic [11:0] CTRL_OFS     = 12'h000;
   localparam logic [11:0] MATCH_OFS    = 12'h004;
   localparam logic [11:0] BASE_OFS     = 12'h008;
   localparam logic [11:0] LEVEL_OFS    = 12'h010;
   localparam logic [11:0] PEND_OFS     = 12'h020;
   localparam logic [11:0] STATUS_OFS   = 12'h024;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [19:0] MATCH_RST    = 20'h0_0000;
   localparam logic [19:0] BASE_RST     = 20'h0_0000;
   localparam logic [2:0]  LEVEL_RST    = 3'h0;
   // ==========================================================
   // Control register fields
   localparam int          AMATCH_EN_BIT = 0;
   localparam int          KEY_EN_LSB    = 4;
   localparam int          EDGE_POL_LSB  = 8;
   localparam int          KEY_LINES     = 4;
   localparam int          EDGE_PINS     = 3;
   localparam int          SHARED_NUMS   = 32;
   // ==========================================================
   // Vectors and source numbers
   localparam logic [19:0] FIXED_BASE   = 20'hF_FFDC;
   localparam logic [3:0]  FIX_UND      = 4'h0;
   localparam logic [3:0]  FIX_OVF      = 4'h1;
   localparam logic [3:0]  FIX_BRK      = 4'h2;
   localparam logic [3:0]  FIX_AMATCH   = 4'h3;
   localparam logic [3:0]  FIX_STEP     = 4'h4;
   localparam logic [3:0]  FIX_WDT      = 4'h5;
   localparam logic [3:0]  FIX_DBG      = 4'h6;
   localparam logic [3:0]  FIX_NMI      = 4'h7;
   localparam logic [3:0]  FIX_RESET    = 4'h8;
   localparam logic [5:0]  KEY_NUM      = 6'h0D;
   localparam logic [5:0]  EDGE_NUM0    = 6'h1D;
   // Special pending bit order, lowest index wins
   localparam int          SP_NMI       = 0;
   localparam int          SP_WDT       = 1;
   localparam int          SP_DBG       = 2;
   localparam int          SP_STEP      = 3;
   localparam int          SP_AMATCH    = 4;
   localparam int          SP_COUNT     = 5;

   typedef enum logic [1:0] {TRAP_UND, TRAP_OVF, TRAP_BRK, TRAP_INT} trap_kind_t;

   typedef struct packed {
      logic       valid;
      trap_kind_t kind;
      logic [5:0] number;
   } trap_req_t;

   typedef struct packed {
      logic [5:0]  number;
      logic [19:0] vector;
      logic        fixed;
      logic        maskable;
      logic [2:0]  level;
   } take_t;

   typedef struct packed {
      logic       found;
      logic [4:0] number;
      logic [2:0] level;
   } best_t;
endpackage
`default_nettype wire

// ===== hdl/interrupt_source_classifier.sv
// Purpose: Sorts traps, special and peripheral requests and hands one to the core
// Assumes: Core asserts accept_ready_i at instruction boundaries; APB zero wait
// Notes:   One saved stack-select level; nested saves are up to core software
// Overview of operation
// - Maskable requests need the global mask flag; priority is a programmed level
// - Non-maskable requests ignore the mask flag and have fixed priority
// - Instruction traps are non-maskable; the mask flag never blocks them
// - Illegal-opcode trap instruction raises the illegal-instruction exception
// - Overflow trap raises an exception only when the overflow flag is 1
// - Breakpoint trap instruction raises the breakpoint exception
// - Numbered trap takes a number 0 to 63 and raises that exception
// - Numbers 0 to 31 share vectors with peripheral sources
// - Numbers 0 to 31 save and clear stack-select; restore on return
// - Numbers 32 to 63 leave stack-select unchanged
// - Reset, pin NMI, debugger break, watchdog, step, match are non-maskable
// - Low level on the reset pin starts the reset sequence
// - Watchdog can raise a non-maskable request
// - With debug step flag 1, raise single-step after one instruction
// - With match enable 1, interrupt before executing the matching address
// - Match fires only on an instruction's first byte address
// - Peripheral requests are maskable and use vectors of numbers 0 to 31
// - Low level on an enabled key line raises the key-input request
// - Each edge pin requests on its selected rising or falling edge
// - Enabled key line low during stop mode ends stop mode
// - Enabled request during wait mode ends wait, clock from subclock
// - Non-maskable pin input is served through the fixed vector table
// - Fixed vectors are four-byte entries from FFFDC to FFFFF
// - Variable vectors are 256 bytes from the table base, four bytes each
`default_nettype none
module interrupt_source_classifier
   import intr_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [11:0]          paddr_i,
   input  wire logic [31:0]          pwdata_i,
   output logic      [31:0]          prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   input  wire trap_req_t            trap_req_i,
   input  wire logic                 overflow_flag_i,
   input  wire logic                 global_mask_flag_i,
   input  wire logic [2:0]           cpu_priority_i,
   input  wire logic                 debug_flag_i,
   input  wire logic                 instr_done_i,
   input  wire logic                 fetch_valid_i,
   input  wire logic                 fetch_first_i,
   input  wire logic [19:0]          fetch_addr_i,
   input  wire logic                 stack_select_i,
   input  wire logic                 return_i,
   input  wire logic                 accept_ready_i,
   input  wire logic                 stop_mode_i,
   input  wire logic                 wait_mode_i,
   input  wire logic                 watchdog_req_i,
   input  wire logic                 debugger_break_i,
   input  wire logic [31:0]          periph_req_i,
   input  wire logic                 reset_pin_n_i,
   input  wire logic                 nmi_pin_n_i,
   input  wire logic [KEY_LINES-1:0] key_wake_lines_n_i,
   input  wire logic [EDGE_PINS-1:0] external_edge_pin_i,
   output logic                      take_o,
   output take_t                     take_info_o,
   output logic                      stack_select_o,
   output logic                      reset_req_o,
   output logic                      stop_wake_o,
   output logic                      wait_wake_o
);
   // ==========================================================
   // Helpers
   function automatic logic [19:0] fixed_vec(input logic [3:0] idx);
      fixed_vec = FIXED_BASE + {14'h0000, idx, 2'b00};
   endfunction

   function automatic logic [19:0] var_vec(input logic [19:0] base, input logic [5:0] num);
      var_vec = base + {12'h000, num, 2'b00};
   endfunction

   function automatic best_t find_best(input logic [31:0] pend, input logic [95:0] lv);
      best_t b;
      b = '0;
      for (int i = 0; i < SHARED_NUMS; i++) begin
         if (pend[i] && lv[3*i +: 3] > b.level) begin
            b.found  = 1'b1;
            b.number = 5'(i);
            b.level  = lv[3*i +: 3];
         end
      end
      find_best = b;
   endfunction

   // ==========================================================
   // Registers
   logic [31:0]          ctrl;
   logic [19:0]          match_addr;
   logic [19:0]          vector_table_base;
   logic [95:0]          level;
   logic [31:0]          periph_pend;
   logic [SP_COUNT-1:0]  sp_pend;
   trap_req_t            trap_pend;
   logic                 saved_flag;
   logic [5:0]           last_number;
   logic [8:0]           pin_s1;
   logic [8:0]           pin_s2;
   logic [8:0]           pin_s3;
   logic                 acc_write;
   logic                 setup_rd;
   logic                 mapped;
   logic [31:0]          rd_data;
   logic [31:0]          periph_set;
   logic [31:0]          periph_clr;
   logic [SP_COUNT-1:0]  sp_set;
   logic [SP_COUNT-1:0]  sp_clr;
   logic                 key_low;
   logic [EDGE_PINS-1:0] edge_evt;
   logic                 amatch_hit;
   logic                 trap_raise;
   logic                 accept;
   logic                 sel_valid;
   logic                 sel_switch;
   take_t                sel;
   best_t                best;
   logic [31:0]          lvl_on;

   // Pin order in the synchroniser: reset, nmi, key lines, edge pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1 <= 9'h1FF;
         pin_s2 <= 9'h1FF;
         pin_s3 <= 9'h1FF;
      end else begin
         pin_s1 <= {reset_pin_n_i, nmi_pin_n_i, key_wake_lines_n_i, external_edge_pin_i};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // ==========================================================
   // APB slave, zero wait states
   assign pready_o  = 1'b1;
   assign acc_write = psel_i && penable_i && pwrite_i;
   assign setup_rd  = psel_i && !penable_i && !pwrite_i;
   assign mapped    = paddr_i == CTRL_OFS || paddr_i == MATCH_OFS || paddr_i == BASE_OFS ||
                      paddr_i[11:4] == LEVEL_OFS[11:4] || paddr_i == PEND_OFS ||
                      paddr_i == STATUS_OFS;
   assign pslverr_o = psel_i && penable_i && !mapped;

   always_comb begin
      rd_data = 32'h0000_0000;
      if (paddr_i == CTRL_OFS) begin
         rd_data = ctrl;
      end else if (paddr_i == MATCH_OFS) begin
         rd_data = {12'h000, match_addr};
      end else if (paddr_i == BASE_OFS) begin
         rd_data = {12'h000, vector_table_base};
      end else if (paddr_i[11:4] == LEVEL_OFS[11:4]) begin
         for (int n = 0; n < 8; n++) begin
            rd_data[4*n +: 3] = level[3*(8*paddr_i[3:2] + n) +: 3];
         end
      end else if (paddr_i == PEND_OFS) begin
         rd_data = periph_pend;
      end else if (paddr_i == STATUS_OFS) begin
         rd_data = {17'h0_0000, trap_pend.valid, saved_flag, stack_select_o, sp_pend,
                    1'b0, last_number};
      end
   end

   // Read data is latched in setup so it is stable for the whole access
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata_o <= rd_data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl              <= CTRL_RST;
         match_addr        <= MATCH_RST;
         vector_table_base <= BASE_RST;
         level             <= {SHARED_NUMS{LEVEL_RST}};
      end else if (acc_write) begin
         if (paddr_i == CTRL_OFS) begin
            ctrl <= pwdata_i;
         end
         if (paddr_i == MATCH_OFS) begin
            match_addr <= pwdata_i[19:0];
         end
         if (paddr_i == BASE_OFS) begin
            vector_table_base <= pwdata_i[19:0];
         end
         if (paddr_i[11:4] == LEVEL_OFS[11:4]) begin
            for (int n = 0; n < 8; n++) begin
               level[3*(8*paddr_i[3:2] + n) +: 3] <= pwdata_i[4*n +: 3];
            end
         end
      end
   end

   // ==========================================================
   // Request capture
   // Key level request
   assign key_low = |(~pin_s2[6:3] & ctrl[KEY_EN_LSB +: KEY_LINES]);

   always_comb begin
      for (int p = 0; p < EDGE_PINS; p++) begin
         edge_evt[p] = ctrl[EDGE_POL_LSB + p] ? (pin_s2[p] && !pin_s3[p])
                                              : (!pin_s2[p] && pin_s3[p]);
      end
   end

   assign amatch_hit = ctrl[AMATCH_EN_BIT] && fetch_valid_i && fetch_first_i &&
                       fetch_addr_i == match_addr;

   // Peripheral sources share numbers 0 to 31
   always_comb begin
      periph_set = periph_req_i;
      periph_set[KEY_NUM[4:0]] = periph_req_i[KEY_NUM[4:0]] || key_low;
      for (int p = 0; p < EDGE_PINS; p++) begin
         periph_set[EDGE_NUM0[4:0] + p] = periph_req_i[EDGE_NUM0[4:0] + p] || edge_evt[p];
      end
      periph_clr = (acc_write && paddr_i == PEND_OFS) ? pwdata_i : 32'h0000_0000;
      if (accept && !sel.fixed && sel.maskable) begin
         periph_clr[sel.number[4:0]] = 1'b1;
      end
   end

   // New events win over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_pend <= 32'h0000_0000;
      end else begin
         periph_pend <= (periph_pend & ~periph_clr) | periph_set;
      end
   end

   always_comb begin
      sp_set            = '0;
      sp_set[SP_NMI]    = !pin_s2[7] && pin_s3[7];
      sp_set[SP_WDT]    = watchdog_req_i;
      sp_set[SP_DBG]    = debugger_break_i;
      sp_set[SP_STEP]   = debug_flag_i && instr_done_i;
      sp_set[SP_AMATCH] = amatch_hit;
      sp_clr            = '0;
      for (int s = 0; s < SP_COUNT; s++) begin
         if (accept && sel.fixed && !trap_pend.valid && sel_switch && s == sel.level) begin
            sp_clr[s] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sp_pend <= '0;
      end else begin
         sp_pend <= (sp_pend & ~sp_clr) | sp_set;
      end
   end

   // Trap capture, overflow trap needs the flag
   assign trap_raise = trap_req_i.valid && (trap_req_i.kind != TRAP_OVF || overflow_flag_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trap_pend <= '0;
      end else if (trap_raise) begin
         trap_pend <= trap_req_i;
      end else if (accept && trap_pend.valid) begin
         trap_pend.valid <= 1'b0;
      end
   end

   // Reset pin starts the reset sequence
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_req_o <= 1'b0;
      end else begin
         reset_req_o <= !pin_s2[8];
      end
   end

   // ==========================================================
   // Selection: traps, then specials, then maskable peripherals
   assign best = find_best(periph_pend, level);

   always_comb begin
      sel_valid  = 1'b0;
      sel_switch = 1'b1;
      sel        = '0;
      lvl_on     = '0;
      for (int i = 0; i < SHARED_NUMS; i++) begin
         lvl_on[i] = level[3*i +: 3] != 3'h0;
      end
      if (trap_pend.valid) begin
         sel_valid = 1'b1;
         sel.fixed = 1'b1;
         case (trap_pend.kind)
            TRAP_UND: sel.vector = fixed_vec(FIX_UND);
            TRAP_OVF: sel.vector = fixed_vec(FIX_OVF);
            TRAP_BRK: sel.vector = fixed_vec(FIX_BRK);
            TRAP_INT: begin
               // Numbered trap uses the variable table
               sel.fixed  = 1'b0;
               sel.number = trap_pend.number;
               sel.vector = var_vec(vector_table_base, trap_pend.number);
               // Upper numbers keep the stack flag
               sel_switch = !trap_pend.number[5];
            end
            default: sel.vector = fixed_vec(FIX_UND);
         endcase
      end else if (sp_pend != '0) begin
         sel_valid = 1'b1;
         sel.fixed = 1'b1;
         for (int s = SP_COUNT - 1; s >= 0; s--) begin
            if (sp_pend[s]) begin
               sel.level = 3'(s);
            end
         end
         case (sel.level)
            3'h0:    sel.vector = fixed_vec(FIX_NMI);
            3'h1:    sel.vector = fixed_vec(FIX_WDT);
            3'h2:    sel.vector = fixed_vec(FIX_DBG);
            3'h3:    sel.vector = fixed_vec(FIX_STEP);
            default: sel.vector = fixed_vec(FIX_AMATCH);
         endcase
      end else if (global_mask_flag_i && best.found && best.level > cpu_priority_i) begin
         // Gate by mask flag and priority level
         sel_valid    = 1'b1;
         sel.maskable = 1'b1;
         sel.number   = {1'b0, best.number};
         sel.level    = best.level;
         sel.vector   = var_vec(vector_table_base, {1'b0, best.number});
      end
   end

   // One acceptance per two cycles so the core sees a clean pulse
   assign accept = accept_ready_i && !reset_req_o && !take_o && sel_valid;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         take_o      <= 1'b0;
         take_info_o <= '0;
         last_number <= 6'h00;
      end else begin
         take_o <= accept;
         if (accept) begin
            take_info_o <= sel;
            last_number <= sel.number;
         end
      end
   end

   // Save and clear the stack flag, restore on return
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stack_select_o <= 1'b0;
         saved_flag     <= 1'b0;
      end else if (accept && sel_switch) begin
         saved_flag     <= stack_select_i;
         stack_select_o <= 1'b0;
      end else if (return_i) begin
         stack_select_o <= saved_flag;
      end else begin
         stack_select_o <= stack_select_i;
      end
   end

   // ==========================================================
   // Low-power wake
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_wake_o <= 1'b0;
         wait_wake_o <= 1'b0;
      end else begin
         stop_wake_o <= stop_mode_i && key_low;
         wait_wake_o <= wait_mode_i && (sp_pend != '0 || (|(periph_pend & lvl_on)));
      end
   end

   // ==========================================================
   // Checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic key_low_raw;
   assign key_low_raw = |(~key_wake_lines_n_i & ctrl[KEY_EN_LSB +: KEY_LINES]);

   a_ovf_no_flag: assert property (
      trap_req_i.valid && trap_req_i.kind == TRAP_OVF && !overflow_flag_i && !trap_pend.valid
      |=> !trap_pend.valid) else $error("overflow trap raised without flag");
   a_trap_unmasked: assert property (
      trap_pend.valid && accept_ready_i && !reset_req_o && !take_o
      |=> take_o && !take_info_o.maskable) else $error("trap not taken");
   a_mask_gate: assert property (
      take_o && take_info_o.maskable
      |-> $past(global_mask_flag_i) && take_info_o.level > $past(cpu_priority_i))
      else $error("maskable taken while masked");
   a_nmi_fixed: assert property (
      $fell(pin_s2[7]) && !trap_pend.valid ##1 accept_ready_i && !take_o && !reset_req_o
      && !trap_pend.valid && sp_pend[SP_NMI] |=> take_o && take_info_o.fixed
      && take_info_o.vector == fixed_vec(FIX_NMI)) else $error("nmi not vectored");
   a_low_int_stack: assert property (
      take_o && !take_info_o.fixed && !take_info_o.number[5] |-> !stack_select_o)
      else $error("stack flag not cleared");
   a_high_int_stack: assert property (
      take_o && !take_info_o.fixed && take_info_o.number[5]
      |-> stack_select_o == $past(stack_select_i)) else $error("stack flag changed");
   a_fixed_range: assert property (
      take_o && take_info_o.fixed |-> take_info_o.vector >= FIXED_BASE
      && take_info_o.vector[1:0] == 2'b00) else $error("fixed vector out of table");
   a_var_range: assert property (
      take_o && !take_info_o.fixed
      |-> take_info_o.vector == var_vec(vector_table_base, take_info_o.number))
      else $error("variable vector wrong");
   a_reset_pin: assert property (
      !reset_pin_n_i [*4] |-> reset_req_o) else $error("reset pin ignored");
   a_step_raise: assert property (
      debug_flag_i && instr_done_i |=> sp_pend[SP_STEP]) else $error("step not raised");
   a_match_first: assert property (
      !sp_pend[SP_AMATCH] && !(fetch_valid_i && fetch_first_i) |=> !sp_pend[SP_AMATCH])
      else $error("match off first byte");
   a_key_stop: assert property (
      (stop_mode_i && key_low_raw) [*4] |-> stop_wake_o) else $error("stop not ended");

   c_trap_take: cover property (take_o && !take_info_o.maskable && !take_info_o.fixed);
   c_periph_take: cover property (take_o && take_info_o.maskable);
   c_stop_wake: cover property (stop_wake_o);
   c_wait_wake: cover property (wait_wake_o);
endmodule
`default_nettype wire

// ===== verification/core_seq_model.sv
// Purpose: Core sequencer stand-in giving the accept window
// Assumes: Accepts on any cycle with ready high
// Notes:   Slow mode opens the window every other cycle only
`default_nettype none
module core_seq_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic slow_i,
   output logic      accept_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Accept window
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accept_ready_o <= 1'b0;
      end else begin
         accept_ready_o <= slow_i ? ~accept_ready_o : 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Purpose: Self-checking bench for the interrupt source classifier
// Assumes: Zero-wait APB slave, take one cycle after accept
// Notes:   Pins idle high; vectors checked, numbers not
`default_nettype none
module tb import intr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr, ovf, gmask, slow, ssel, ret, wdt;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, preq, r;
   trap_req_t   trq;
   take_t       info;
   logic        take, sso, ardy, sst;
   logic [2:0]  prio, edges;
   logic        dbg, idone, fval, ffst, stopm, waitm, dbrk, rpin, npin;
   logic [19:0] faddr;
   logic [3:0]  keys;
   int          bad_count, cmp_count, cyc;
   localparam logic [19:0] TB_BASE = 20'h1_2300;
   // ==========================================
   // Instances
   core_seq_model i_core_seq_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
      .accept_ready_o(ardy));
   interrupt_source_classifier i_interrupt_source_classifier (.clk_i(clk_i), .rst_i(rst_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .trap_req_i(trq), .overflow_flag_i(ovf), .global_mask_flag_i(gmask),
      .cpu_priority_i(prio), .debug_flag_i(dbg), .instr_done_i(idone),
      .fetch_valid_i(fval), .fetch_first_i(ffst), .fetch_addr_i(faddr),
      .stack_select_i(ssel), .return_i(ret), .accept_ready_i(ardy), .stop_mode_i(stopm),
      .wait_mode_i(waitm), .watchdog_req_i(wdt), .debugger_break_i(dbrk),
      .periph_req_i(preq), .reset_pin_n_i(rpin), .nmi_pin_n_i(npin),
      .key_wake_lines_n_i(keys), .external_edge_pin_i(edges), .take_o(take),
      .take_info_o(info), .stack_select_o(sso), .reset_req_o(), .stop_wake_o(),
      .wait_wake_o());
   // ==========================================
   // Clock and timeout
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         end_of_test();
      end
   end
   // ==========================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i) begin psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; end
      @(posedge clk_i) penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      r = pslverr ? 32'hDEAD_0000 : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic trap(input trap_kind_t k, input logic [5:0] n);
      @(posedge clk_i) trq <= '{valid: 1'b1, kind: k, number: n};
      @(posedge clk_i) trq <= '0;
   endtask
   task automatic take_wait(input logic [19:0] vec, input logic fx, input logic mk,
                            input logic exp_take);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_i);
         #1;
         if (take === 1'b1 && !seen) begin
            seen = 1'b1;
            sst = sso;
            chk(info.vector, vec);
            chk(info.fixed, fx);
            chk(info.maskable, mk);
         end
      end
      chk(seen, exp_take);
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, ovf, gmask, slow, ret, wdt} = '0;
      {paddr, pwdata, preq, bad_count, cmp_count, cyc} = '0;
      trq = '0;
      {prio, dbg, idone, fval, ffst, faddr, stopm, waitm, dbrk, sst} = '0;
      {rpin, npin, keys, edges} = '1;
      ssel = 1'b1;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      apb(1'b1, BASE_OFS, {12'h000, TB_BASE});
      apb(1'b0, BASE_OFS, 32'h0);
      chk(r, {12'h000, TB_BASE});
      apb(1'b0, 12'h0FC, 32'h0);
      chk(r, 32'hDEAD_0000);
      $display("test registers done");
      trap(TRAP_INT, 6'd5);
      take_wait(TB_BASE + 20'd20, 1'b0, 1'b0, 1'b1);
      chk(sst, 1'b0);
      @(posedge clk_i) begin
         ret <= 1'b1;
         ssel <= 1'b0;
      end
      @(posedge clk_i) ret <= 1'b0;
      #1;
      chk(sso, 1'b1);
      ssel <= 1'b1;
      trap(TRAP_INT, 6'd40);
      take_wait(TB_BASE + 20'd160, 1'b0, 1'b0, 1'b1);
      chk(sst, 1'b1);
      trap(TRAP_OVF, 6'd0);
      take_wait(20'h0_0000, 1'b0, 1'b0, 1'b0);
      ovf <= 1'b1;
      trap(TRAP_OVF, 6'd0);
      take_wait(FIXED_BASE + 20'h0_0004, 1'b1, 1'b0, 1'b1);
      trap(TRAP_BRK, 6'd0);
      take_wait(FIXED_BASE + 20'h0_0008, 1'b1, 1'b0, 1'b1);
      trap(TRAP_UND, 6'd0);
      take_wait(FIXED_BASE, 1'b1, 1'b0, 1'b1);
      $display("test traps done");
      apb(1'b1, LEVEL_OFS + 12'h008, 32'h0030_0000);
      @(posedge clk_i) preq <= 32'h0020_0000;
      @(posedge clk_i) preq <= '0;
      take_wait(20'h0_0000, 1'b0, 1'b0, 1'b0);
      gmask <= 1'b1;
      take_wait(TB_BASE + 20'd84, 1'b0, 1'b1, 1'b1);
      $display("test peripheral done");
      gmask <= 1'b0;
      slow <= 1'b1;
      @(posedge clk_i) wdt <= 1'b1;
      @(posedge clk_i) wdt <= 1'b0;
      take_wait(FIXED_BASE + 20'h0_0014, 1'b1, 1'b0, 1'b1);
      $display("test watchdog done");
      @(posedge clk_i) npin <= 1'b0;
      take_wait(FIXED_BASE + 20'h0_001C, 1'b1, 1'b0, 1'b1);
      @(posedge clk_i) {dbg, idone} <= 2'b11;
      @(posedge clk_i) {dbg, idone} <= 2'b00;
      take_wait(FIXED_BASE + 20'h0_0010, 1'b1, 1'b0, 1'b1);
      $display("test nmi and step done");
      end_of_test();
   end
endmodule
`default_nettype wire
